// ===== design/rcsr_top.sv
// reset cause recorder with software reset trigger, apb slave
// assumes event pulses on pclk; master clear pin is asynchronous
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns

module rcsr_top
  import rcsr_pkg::*;
#(
  parameter int RST_CYC = RCSR_RST_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rcsr_evt_t evt,
  input wire logic master_clear_pin_n,
  output logic master_system_reset,
  output logic unlocked
);

  // ==========================================================
  // master clear pin synchroniser
  logic [2:0] pin_sync_r;
  logic pin_low_r;
  logic pin_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 3'h7;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], master_clear_pin_n};
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_low_r <= 1'b0;
    end else if (pin_sync_r[1] == pin_sync_r[2]) begin
      pin_low_r <= ~pin_sync_r[2];
    end
  end

  assign pin_fall = (pin_sync_r[1] == pin_sync_r[2]) &&
                    !pin_sync_r[2] && !pin_low_r;

  // ==========================================================
  // apb access decode
  rcsr_bus_t bus_r;
  logic [31:0] status_r;
  logic arm_r;
  logic unlock_r;
  logic [31:0] rd_nxt;
  logic hit_status;
  logic hit_trig;
  logic hit_unlock;
  logic mapped;
  logic done;
  logic wr;
  logic rd;
  logic [3:0] ofs;

  assign ofs = paddr[3:0];
  assign hit_status = (paddr[15:4] == RCSR_STATUS_ADDR[15:4]);
  assign hit_trig = (paddr[15:4] == RCSR_TRIG_ADDR[15:4]);
  assign hit_unlock = (paddr == RCSR_UNLOCK_ADDR);
  assign mapped = ((hit_status || hit_trig) && (ofs[1:0] == 2'h0))
                  || hit_unlock;
  assign done = psel && penable && (bus_r == RCSR_DONE);
  assign wr = done && pwrite && mapped;
  assign rd = done && !pwrite && mapped;

  // one wait state: setup, access, then pready at the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_r <= RCSR_IDLE;
    end else begin
      case (bus_r)
        RCSR_IDLE: begin
          if (psel && !penable) begin
            bus_r <= RCSR_ACC;
          end
        end
        RCSR_ACC: begin
          if (psel && penable) begin
            bus_r <= RCSR_DONE;
          end else if (!psel) begin
            bus_r <= RCSR_IDLE;
          end
        end
        RCSR_DONE: begin
          bus_r <= RCSR_IDLE;
        end
        default: begin
          bus_r <= RCSR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= (bus_r == RCSR_ACC) && psel && penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= (bus_r == RCSR_ACC) && psel && penable && !mapped;
    end
  end

  // write-only trigger, unlock state only bit 0
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit_status) begin
      rd_nxt = status_r & RCSR_STATUS_MASK;
    end else if (hit_trig) begin
      rd_nxt = 32'h0000_0000;
    end else if (hit_unlock) begin
      rd_nxt = {31'h0000_0000, unlock_r};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if ((bus_r == RCSR_ACC) && psel && penable && !pwrite) begin
      prdata <= rd_nxt;
    end
  end

  // ==========================================================
  // system unlock
  // any write other than the key to the unlock register locks again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_r <= 1'b0;
    end else if (wr && hit_unlock) begin
      unlock_r <= (pwdata == RCSR_UNLOCK_KEY);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlocked <= 1'b0;
    end else begin
      unlocked <= unlock_r;
    end
  end

  // ==========================================================
  // software reset trigger
  logic arm_wr;
  logic soft_fire;
  logic [31:0] rst_cnt_r;

  assign arm_wr = wr && hit_trig && unlock_r &&
                  (ofs != RCSR_OFS_CLR) &&
                  pwdata[RCSR_B_ARM];
  assign soft_fire = arm_r && rd && hit_trig;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_r <= 1'b0;
    end else if (soft_fire) begin
      arm_r <= 1'b0;
    end else if (arm_wr) begin
      arm_r <= 1'b1;
    end
  end

  // ==========================================================
  // master system reset merge
  logic any_src;

  assign any_src = soft_fire || pin_fall || evt.wdog || evt.brown ||
                   evt.mismatch || evt.supply_por ||
                   evt.core_por;

  // stretched so the whole chip sees a clean pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_r <= 32'h0000_0000;
    end else if (any_src) begin
      rst_cnt_r <= 32'(RST_CYC);
    end else if (rst_cnt_r != 32'h0000_0000) begin
      rst_cnt_r <= rst_cnt_r - 32'h0000_0001;
    end
  end

  // held asserted during power-on and for as long as the pin is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_system_reset <= 1'b1;
    end else begin
      master_system_reset <= any_src || pin_low_r ||
                             (rst_cnt_r > 32'h0000_0001);
    end
  end

  // ==========================================================
  // reset cause status flags
  // only presetn (power-on) and software writes clear these, never the system reset
  logic [31:0] set_vec;

  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[RCSR_B_SUPPLY_POR] = evt.supply_por;
    set_vec[RCSR_B_CORE_POR] = evt.core_por;
    set_vec[RCSR_B_CFG_ERR] = evt.cfg_err;
    set_vec[RCSR_B_CFG_FAIL] = evt.cfg_fail;
    set_vec[RCSR_B_MISMATCH] = evt.mismatch;
    set_vec[RCSR_B_PIN] = pin_fall;
    set_vec[RCSR_B_SOFT] = soft_fire;
    set_vec[RCSR_B_WDOG] = evt.wdog;
    set_vec[RCSR_B_SLEEP] = evt.sleep_wake;
    set_vec[RCSR_B_IDLE] = evt.idle_wake || evt.sleep_wake;
    set_vec[RCSR_B_BROWN] = evt.brown;
    set_vec[RCSR_B_POR] = evt.supply_por || evt.core_por;
  end

  // one flag per bit; unimplemented positions hold no storage at all
  for (genvar gi = 0; gi < 32; gi++) begin : g_flag
    if (RCSR_STATUS_MASK[gi]) begin : g_impl
      logic flag_r;
      logic flag_nxt;

      always_comb begin
        flag_nxt = flag_r;
        if (wr && hit_status) begin
          case (ofs)
            RCSR_OFS_BASE: flag_nxt = pwdata[gi];
            RCSR_OFS_CLR: flag_nxt = flag_r & ~pwdata[gi];
            RCSR_OFS_SET: flag_nxt = flag_r | pwdata[gi];
            RCSR_OFS_INV: flag_nxt = flag_r ^ pwdata[gi];
            default: flag_nxt = flag_r;
          endcase
        end
        // a hardware set in the same cycle beats a software clear
        flag_nxt = flag_nxt | set_vec[gi];
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_r <= RCSR_STATUS_RST[gi];
        end else begin
          flag_r <= flag_nxt;
        end
      end

      assign status_r[gi] = flag_r;
    end else begin : g_rsvd
      assign status_r[gi] = 1'b0;
    end
  end

endmodule : rcsr_top

// ===== shared/rcsr_pkg.sv
// reset cause status and software reset trigger: constants and types
// assumes an apb slave on a 10 mhz pclk, byte addresses, 32-bit words

package rcsr_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] RCSR_STATUS_ADDR = 16'h1240;
  localparam logic [15:0] RCSR_TRIG_ADDR = 16'h1250;
  localparam logic [15:0] RCSR_UNLOCK_ADDR = 16'h1260;
  localparam logic [3:0] RCSR_OFS_BASE = 4'h0;
  localparam logic [3:0] RCSR_OFS_CLR = 4'h4;
  localparam logic [3:0] RCSR_OFS_SET = 4'h8;
  localparam logic [3:0] RCSR_OFS_INV = 4'hc;

  // ==========================================================
  // status field positions
  localparam int RCSR_B_SUPPLY_POR = 31;
  localparam int RCSR_B_CORE_POR = 30;
  localparam int RCSR_B_CFG_ERR = 27;
  localparam int RCSR_B_CFG_FAIL = 26;
  localparam int RCSR_B_MISMATCH = 9;
  localparam int RCSR_B_PIN = 7;
  localparam int RCSR_B_SOFT = 6;
  localparam int RCSR_B_WDOG = 4;
  localparam int RCSR_B_SLEEP = 3;
  localparam int RCSR_B_IDLE = 2;
  localparam int RCSR_B_BROWN = 1;
  localparam int RCSR_B_POR = 0;
  localparam int RCSR_B_ARM = 0;

  localparam logic [31:0] RCSR_STATUS_MASK = 32'hcc00_02df;
  localparam logic [31:0] RCSR_STATUS_RST = 32'hc000_0003;
  localparam logic [31:0] RCSR_TRIG_MASK = 32'h0000_0001;

  // ==========================================================
  // unlock key and system reset stretch
  localparam logic [31:0] RCSR_UNLOCK_KEY = 32'h5a5a_a5a5;
  localparam int RCSR_RST_NS = 1600;
  localparam int RCSR_CLK_NS = 100;
  localparam int RCSR_RST_CYC = (RCSR_RST_NS + RCSR_CLK_NS - 1)
                                / RCSR_CLK_NS;

  // ==========================================================
  // event group from the surrounding reset and power logic
  typedef struct packed {
    logic supply_por;
    logic core_por;
    logic cfg_err;
    logic cfg_fail;
    logic mismatch;
    logic wdog;
    logic sleep_wake;
    logic idle_wake;
    logic brown;
  } rcsr_evt_t;

  typedef enum logic [1:0] {
    RCSR_IDLE = 2'b00,
    RCSR_ACC = 2'b01,
    RCSR_DONE = 2'b10
  } rcsr_bus_t;

endpackage : rcsr_pkg

// ===== tb/rcsr_chk.sv
// checker for rcsr_top: bus timing, reserved bits, reset sources
// assumes one pclk domain; bound to rcsr_top at the foot
`timescale 1ns/1ns
module rcsr_chk
  import rcsr_pkg::*;
#(parameter int RST_CYC = RCSR_RST_CYC) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rcsr_evt_t evt,
  input wire logic master_clear_pin_n,
  input wire logic master_system_reset,
  input wire logic unlocked
);
  // ==========================================================
  // helpers
  int hi_cnt;
  logic key_wr;
  logic rd_ok;
  assign key_wr = pready && pwrite && paddr == RCSR_UNLOCK_ADDR &&
                  pwdata == RCSR_UNLOCK_KEY;
  assign rd_ok = pready && !pwrite;
  // seeded so the fall at reset release does not fire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt <= RST_CYC;
    else hi_cnt <= master_system_reset ? hi_cnt + 1 : 0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // assertions
  chk_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_err_ready: assert property (pslverr |->
    pready && (pwrite || prdata == 32'h0)) else $error("bad pslverr");
  chk_status_rsvd: assert property (rd_ok
    && paddr[15:4] == RCSR_STATUS_ADDR[15:4] |->
    (prdata & ~RCSR_STATUS_MASK) == 32'h0) else $error("rsvd set");
  chk_trig_zero: assert property (rd_ok
    && paddr[15:4] == RCSR_TRIG_ADDR[15:4] |-> prdata[31:1] == 31'h0)
    else $error("trigger reads ones");
  chk_evt_reset: assert property (|{evt.wdog, evt.brown,
    evt.mismatch, evt.supply_por} |=> master_system_reset)
    else $error("no reset on event");
  chk_pin_reset: assert property (!master_clear_pin_n [*6] |->
    master_system_reset) else $error("no reset on pin");
  chk_rst_stretch: assert property ($fell(master_system_reset) |->
    hi_cnt >= RST_CYC) else $error("reset pulse short");
  chk_unlock_src: assert property ($rose(unlocked) |->
    $past(key_wr) || $past(key_wr, 2)) else $error("unlock no key");
  cover property (key_wr);
  cover property ($rose(master_system_reset));
  cover property (pslverr);
endmodule : rcsr_chk

bind rcsr_top rcsr_chk #(.RST_CYC(RST_CYC)) u_rcsr_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .evt(evt),
  .master_clear_pin_n(master_clear_pin_n),
  .master_system_reset(master_system_reset), .unlocked(unlocked));

// ===== tb/test_rcsr_top.sv
// self-checking bench for rcsr_top through apb
// assumes rcsr_pkg and the bound checker compiled first
`timescale 1ns/1ns
module test_rcsr_top
  import rcsr_pkg::*;
;
  localparam logic [15:0] ST = RCSR_STATUS_ADDR;
  localparam logic [15:0] TR = RCSR_TRIG_ADDR;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, msr, unlocked;
  logic pin_n = 1'b1;
  logic seen = 1'b0;
  rcsr_evt_t evt = 9'h0;
  logic [31:0] ev_exp [9] = '{32'h2, 32'h4, 32'hc, 32'h10, 32'h200,
    32'h0400_0000, 32'h0800_0000, 32'h4000_0001, 32'h8000_0001};
  int n_errors = 0;
  int n_compared = 0;

  rcsr_top #(.RST_CYC(2)) u_rcsr_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .master_clear_pin_n(pin_n),
    .master_system_reset(msr), .unlocked(unlocked));

  always #50 pclk = ~pclk;
  // reset pulse is short, so latch it for later checks
  always @(posedge pclk) if (msr) seen <= 1'b1;

  // ==========================================================
  // bus and compare tasks
  task automatic finish_test;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic cmp(input string nm, input logic [31:0] ex, got);
    n_compared++;
    if (got !== ex) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // judged at rising edges only, request held until pready is seen
    for (i = 0; i < 9; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 9) begin
      cmp("pready", 32'h1, 32'h0);
      finish_test();
    end
  endtask : apb

  task automatic rdc(input string nm, input logic [15:0] a,
                     input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    cmp(nm, ex, rd);
  endtask : rdc

  task automatic seen_is(input string nm, input logic ex);
    repeat (6) @(posedge pclk);
    cmp(nm, 32'(ex), 32'(seen));
    seen <= 1'b0;
  endtask : seen_is

  // ==========================================================
  // scenarios
  task automatic t_alias;
    apb(1'b1, ST + 16'h8, 32'hffff_ffff);
    rdc("set alias", ST, RCSR_STATUS_MASK);
    apb(1'b1, ST + 16'hc, 32'h0000_0011);
    rdc("inv alias", ST, RCSR_STATUS_MASK ^ 32'h11);
    apb(1'b1, ST, 32'hffff_ffff);
    rdc("base write", ST, RCSR_STATUS_MASK);
    apb(1'b1, ST + 16'h4, 32'hffff_ffff);
    rdc("clr alias", ST, 32'h0);
  endtask : t_alias

  task automatic t_events;
    for (int i = 0; i < 9; i++) begin
      @(posedge pclk);
      evt <= rcsr_evt_t'(9'h1 << i);
      @(posedge pclk);
      evt <= 9'h0;
      repeat (6) @(posedge pclk);
      rdc("event flag", ST, ev_exp[i]);
      rdc("flag kept", ST, ev_exp[i]);
      apb(1'b1, ST + 16'h4, 32'hffff_ffff);
    end
  endtask : t_events

  task automatic t_pin;
    @(posedge pclk);
    seen <= 1'b0;
    pin_n <= 1'b0;
    repeat (8) @(posedge pclk);
    pin_n <= 1'b1;
    seen_is("pin reset", 1'b1);
    rdc("pin flag", ST, 32'h80);
    apb(1'b1, ST + 16'h4, 32'hffff_ffff);
  endtask : t_pin

  task automatic t_soft;
    apb(1'b1, TR, 32'h1);
    rdc("locked trigger", TR, 32'h0);
    seen_is("locked no reset", 1'b0);
    apb(1'b1, RCSR_UNLOCK_ADDR, RCSR_UNLOCK_KEY);
    rdc("unlock state", RCSR_UNLOCK_ADDR, 32'h1);
    cmp("unlocked", 32'h1, 32'(unlocked));
    apb(1'b1, TR, 32'h0);
    rdc("zero write", TR, 32'h0);
    seen_is("zero no reset", 1'b0);
    apb(1'b1, TR + 16'h8, 32'h1);
    rdc("armed read", TR, 32'h0);
    seen_is("soft reset", 1'b1);
    rdc("soft flag", ST, 32'h40);
    rdc("disarmed read", TR, 32'h0);
    seen_is("arm cleared", 1'b0);
  endtask : t_soft

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc("status at reset", ST, RCSR_STATUS_RST);
    rdc("trigger at reset", TR, 32'h0);
    cmp("unlocked at reset", 32'h0, 32'(unlocked));
    t_alias();
    t_events();
    t_pin();
    t_soft();
    apb(1'b0, 16'h1300, 32'h0);
    cmp("unmapped err", 32'h1, 32'(er));
    cmp("unmapped data", 32'h0, rd);
    finish_test();
  end
endmodule : test_rcsr_top
